// file: core/xdpc_decode.sv
// three-lane decode stage: operand fields and fast / microcoded path sort
`timescale 1ns/1ps
`default_nettype none
`include "xdpc_regs.svh"
module xdpc_decode
  import xdpc_pkg::*;
#(
  parameter int LANES = `XDPC_LANES,
  parameter int AW    = 32
) (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_arst_n,
  input  wire logic [LANES-1:0]     i_valid,
  output logic                      o_ready,
  input  wire logic [LANES*8-1:0]   i_op0,
  input  wire logic [LANES*8-1:0]   i_op1,
  input  wire logic [LANES-1:0]     i_two_byte,
  input  wire logic [LANES*8-1:0]   i_modrm,
  input  wire logic [LANES-1:0]     i_has_modrm,
  input  wire logic [LANES*3-1:0]   i_opc_reg,
  input  wire logic [LANES-1:0]     i_reg_in_opc,
  input  wire logic [LANES*2-1:0]   i_size,
  input  wire logic [LANES*8-1:0]   i_trail,
  input  wire logic [LANES*AW-1:0]  i_addr,
  input  wire logic                 i_stall,
  output logic [LANES-1:0]          o_valid,
  output logic [LANES*2-1:0]        o_cls,
  output logic [LANES*3-1:0]        o_pipes,
  output logic [LANES-1:0]          o_reg_form,
  output logic [LANES*3-1:0]        o_primary_reg,
  output logic [LANES*3-1:0]        o_secondary_reg,
  output logic [LANES*2-1:0]        o_size,
  output logic [LANES*2-1:0]        o_kind,
  output logic [LANES*3-1:0]        o_stack_ofs,
  output logic [LANES*8-1:0]        o_vs_opcode,
  output logic [LANES-1:0]          o_prefetch,
  output logic [LANES*AW-1:0]       o_line_addr
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [LANES-1:0]    vld;
    logic [LANES*2-1:0]  cls;
    logic [LANES*3-1:0]  pipes;
    logic [LANES-1:0]    rform;
    logic [LANES*3-1:0]  preg;
    logic [LANES*3-1:0]  sreg;
    logic [LANES*2-1:0]  size;
    logic [LANES*2-1:0]  kind;
    logic [LANES*3-1:0]  stk;
    logic [LANES*8-1:0]  vsop;
    logic [LANES-1:0]    pref;
    logic [LANES*AW-1:0] line;
  } xdpc_state_s;

  xdpc_state_s st_q;
  xdpc_state_s st_d;
  xdpc_lut_s   ent [LANES];

  function automatic logic is_fp_esc(input logic [7:0] op);
    is_fp_esc = op[7:3] == 5'h1b;
  endfunction : is_fp_esc

  // ----------------------------------------------------------------
  // per-lane table lookup
  // ----------------------------------------------------------------
  for (genvar g = 0; g < LANES; g++) begin : g_lut
    xdpc_lut u_lut (
      .i_op0       (i_two_byte[g] ? `XDPC_OP_ESC : i_op0[g*8 +: 8]),
      .i_op1       (i_two_byte[g] ? i_op1[g*8 +: 8] : i_op1[g*8 +: 8]),
      .i_modrm     (i_modrm[g*8 +: 8]),
      .i_has_modrm (i_has_modrm[g]),
      .o_ent       (ent[g])
    );
  end

  assign o_ready = !i_stall; // all lanes accepted together

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0]    m;
    logic [7:0]    o0;
    logic [7:0]    o1;
    logic          rfm;
    logic          vs;
    logic          simd;
    logic          fp;
    logic          pf;
    logic          gpr_x;
    m     = 8'h00;
    o0    = 8'h00;
    o1    = 8'h00;
    rfm   = 1'b0;
    vs    = 1'b0;
    simd  = 1'b0;
    fp    = 1'b0;
    pf    = 1'b0;
    gpr_x = 1'b0;
    st_d  = st_q;
    if (!i_stall) begin
      for (int l = 0; l < LANES; l++) begin
        m     = i_modrm[l*8 +: 8];
        o0    = i_op0[l*8 +: 8];
        o1    = i_op1[l*8 +: 8];
        rfm   = i_has_modrm[l]
                && m[`XDPC_MOD_HI:`XDPC_MOD_LO] == `XDPC_MOD_REG;
        fp    = !i_two_byte[l] && is_fp_esc(o0);
        vs    = i_two_byte[l] && o1 == `XDPC_OP_VSIMD;
        pf    = i_two_byte[l] && (o1 == `XDPC_OP_PREF || o1 == `XDPC_OP_PREF_SSE);
        simd  = i_two_byte[l] && (vs || o1[7:4] >= 4'h6);
        gpr_x = i_two_byte[l] && (o1 == 8'h7e || o1 == 8'h6e || o1 == 8'hc5);
        st_d.vld[l]          = i_valid[l];
        st_d.rform[l]        = rfm;
        // table class applies to reg and mem forms
        st_d.cls[l*2 +: 2]   = i_valid[l] ? ent[l].cls : XDPC_CLS_NONE;
        st_d.pipes[l*3 +: 3] = (i_valid[l] && ent[l].cls == XDPC_CLS_FAST
                                && (fp || simd)) ? ent[l].pipes : 3'h0;
        if (vs) begin
          st_d.cls[l*2 +: 2] = i_valid[l] ? XDPC_CLS_FAST : XDPC_CLS_NONE;
        end
        st_d.preg[l*3 +: 3]  = i_reg_in_opc[l] ? i_opc_reg[l*3 +: 3]
                                               : m[`XDPC_REG_HI:`XDPC_REG_LO];
        st_d.sreg[l*3 +: 3]  = m[`XDPC_RM_HI:`XDPC_RM_LO];
        st_d.size[l*2 +: 2]  = i_size[l*2 +: 2];
        st_d.kind[l*2 +: 2]  = vs ? XDPC_KIND_VS : simd ? XDPC_KIND_SIMD
                              : fp ? XDPC_KIND_FP : XDPC_KIND_INT;
        st_d.stk[l*3 +: 3]   = (fp && rfm) ? m[`XDPC_RM_HI:`XDPC_RM_LO] : 3'h0;
        st_d.vsop[l*8 +: 8]  = vs ? i_trail[l*8 +: 8] : 8'h00;
        st_d.pref[l]         = i_valid[l] && pf && !rfm;
        st_d.line[l*AW +: AW] = pf ? {i_addr[l*AW + `XDPC_LINE_LSB +: AW - `XDPC_LINE_LSB],
                                      {`XDPC_LINE_LSB{1'b0}}}
                                   : i_addr[l*AW +: AW];
        if (gpr_x) begin
          st_d.sreg[l*3 +: 3] = m[`XDPC_RM_HI:`XDPC_RM_LO];
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_valid         = st_q.vld;
  assign o_cls           = st_q.cls;
  assign o_pipes         = st_q.pipes;
  assign o_reg_form      = st_q.rform;
  assign o_primary_reg   = st_q.preg;
  assign o_secondary_reg = st_q.sreg;
  assign o_size          = st_q.size;
  assign o_kind          = st_q.kind;
  assign o_stack_ofs     = st_q.stk;
  assign o_vs_opcode     = st_q.vsop;
  assign o_prefetch      = st_q.pref;
  assign o_line_addr     = st_q.line;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_rform;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (i_arst_n && !i_stall && i_valid[0] && i_has_modrm[0] && i_modrm[7:6] != 2'h3)
        |=> !o_reg_form[0];
  endproperty
  a_rform: assert property (p_rform) else $error("memory form flagged as register");

  property p_sreg;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (i_arst_n && !i_stall) |=> o_secondary_reg[2:0] == $past(i_modrm[2:0]);
  endproperty
  a_sreg: assert property (p_sreg) else $error("secondary register mismatch");

  property p_preg;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (i_arst_n && !i_stall && !i_reg_in_opc[1])
        |=> o_primary_reg[5:3] == $past(i_modrm[13:11]);
  endproperty
  a_preg: assert property (p_preg) else $error("primary register mismatch");

  property p_three;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (i_arst_n && !i_stall && i_valid == 3'h7) |=> o_valid == 3'h7;
  endproperty
  a_three: assert property (p_three) else $error("lane dropped");

  property p_cls;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      o_valid[0] |-> o_cls[1:0] != XDPC_CLS_NONE;
  endproperty
  a_cls: assert property (p_cls) else $error("valid lane unclassified");

  property p_pipes;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      o_cls[1:0] != XDPC_CLS_FAST |-> o_pipes[2:0] == 3'h0;
  endproperty
  a_pipes: assert property (p_pipes) else $error("pipes on non-fast lane");

  property p_vs;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (i_arst_n && !i_stall && i_valid[0] && i_two_byte[0] && i_op1[7:0] == 8'h0f)
        |=> o_cls[1:0] == XDPC_CLS_FAST && o_vs_opcode[7:0] == $past(i_trail[7:0]);
  endproperty
  a_vs: assert property (p_vs) else $error("vendor simd not fast");

  property p_line;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      o_prefetch[0] |-> o_line_addr[5:0] == 6'h00;
  endproperty
  a_line: assert property (p_line) else $error("prefetch line not aligned");
endmodule : xdpc_decode
`default_nettype wire

// file: core/xdpc_regs.svh
// constants of the decode path classifier
`ifndef XDPC_REGS_SVH
`define XDPC_REGS_SVH
`define XDPC_LANES       3
`define XDPC_MOD_HI      7
`define XDPC_MOD_LO      6
`define XDPC_REG_HI      5
`define XDPC_REG_LO      3
`define XDPC_RM_HI       2
`define XDPC_RM_LO       0
`define XDPC_MOD_REG     2'h3
`define XDPC_LINE_BYTES  64
`define XDPC_LINE_LSB    6
`define XDPC_OP_ESC      8'h0f
`define XDPC_OP_VSIMD    8'h0f
`define XDPC_OP_PREF     8'h0d
`define XDPC_OP_PREF_SSE 8'h18
`endif

// file: core/xdpc_pkg.sv
// types of the decode path classifier
package xdpc_pkg;
  typedef enum logic [1:0] {
    XDPC_CLS_NONE  = 2'h0,
    XDPC_CLS_FAST  = 2'h1,
    XDPC_CLS_MCODE = 2'h3
  } xdpc_cls_e;

  typedef enum logic [1:0] {
    XDPC_SZ_BYTE  = 2'h0,
    XDPC_SZ_WORD  = 2'h1,
    XDPC_SZ_DWORD = 2'h2
  } xdpc_size_e;

  typedef enum logic [1:0] {
    XDPC_KIND_INT  = 2'h0,
    XDPC_KIND_FP   = 2'h1,
    XDPC_KIND_SIMD = 2'h2,
    XDPC_KIND_VS   = 2'h3
  } xdpc_kind_e;

  // pipe set bits: add, multiply, store
  typedef logic [2:0] xdpc_pipes_t;

  typedef struct packed {
    xdpc_cls_e   cls;
    xdpc_pipes_t pipes;
  } xdpc_lut_s;
endpackage : xdpc_pkg

// file: core/xdpc_lut.sv
// opcode and reg-field lookup giving path class and fp pipe set
`timescale 1ns/1ps
`default_nettype none
`include "xdpc_regs.svh"
module xdpc_lut
  import xdpc_pkg::*;
(
  input  wire logic [7:0] i_op0,
  input  wire logic [7:0] i_op1,
  input  wire logic [7:0] i_modrm,
  input  wire logic       i_has_modrm,
  output var xdpc_lut_s   o_ent
);
  localparam xdpc_pipes_t P_A   = 3'h1;
  localparam xdpc_pipes_t P_M   = 3'h2;
  localparam xdpc_pipes_t P_S   = 3'h4;
  localparam xdpc_pipes_t P_AM  = 3'h3;
  localparam xdpc_pipes_t P_AMS = 3'h7;

  function automatic xdpc_lut_s ent(input xdpc_cls_e c, input xdpc_pipes_t p);
    ent.cls   = c;
    ent.pipes = p;
  endfunction : ent

  logic       reg_form;
  logic [2:0] rf;
  always_comb begin
    reg_form = i_modrm[7:6] == `XDPC_MOD_REG;
    rf       = i_modrm[5:3];
    o_ent    = ent(XDPC_CLS_FAST, 3'h0);
    unique case (i_op0)
      8'h37, 8'h3f, 8'hd4, 8'hd5: o_ent = ent(XDPC_CLS_MCODE, 3'h0);
      8'h9b: o_ent = ent(XDPC_CLS_FAST, 3'h0);
      8'hda, 8'hde: begin
        if (!reg_form) o_ent = ent(XDPC_CLS_MCODE, 3'h0);
        else if (i_op0 == 8'hda && i_op1 == 8'he9) o_ent = ent(XDPC_CLS_FAST, P_A);
        else if (rf == 3'h4 || rf == 3'h5) o_ent = ent(XDPC_CLS_FAST, P_A);
        else o_ent = ent(XDPC_CLS_FAST, P_AM);
      end
      8'hdb: begin
        if (!reg_form && (rf == 3'h0 || rf == 3'h2 || rf == 3'h3))
          o_ent = ent(XDPC_CLS_FAST, P_S);
        else if (!reg_form && rf == 3'h5) o_ent = ent(XDPC_CLS_MCODE, 3'h0);
        else if (i_op1 == 8'he3) o_ent = ent(XDPC_CLS_MCODE, 3'h0);
        else o_ent = ent(XDPC_CLS_MCODE, P_A);
      end
      8'hdf: begin
        if (!reg_form && rf != 3'h1 && rf != 3'h4 && rf != 3'h6)
          o_ent = ent(XDPC_CLS_FAST, P_S);
        else o_ent = ent(XDPC_CLS_MCODE, reg_form ? P_A : 3'h0);
      end
      8'hd8, 8'hdc: o_ent = ent(XDPC_CLS_FAST, (rf == 3'h1) ? P_M : P_A);
      8'hd9: begin
        if (!reg_form) begin
          if (rf == 3'h0) o_ent = ent(XDPC_CLS_FAST, P_AMS);
          else if (rf == 3'h3 || rf == 3'h2) o_ent = ent(XDPC_CLS_FAST, P_AM);
          else o_ent = ent(XDPC_CLS_MCODE, 3'h0);
        end else if (rf == 3'h0) o_ent = ent(XDPC_CLS_FAST, P_AM);
        else if (rf == 3'h1) o_ent = ent(XDPC_CLS_FAST, P_AMS);
        else if (i_op1 == 8'hf7 || i_op1 == 8'hf6) o_ent = ent(XDPC_CLS_FAST, P_AMS);
        else if (i_op1 == 8'he8) o_ent = ent(XDPC_CLS_FAST, P_S);
        else if (i_op1 == 8'he4) o_ent = ent(XDPC_CLS_FAST, P_A);
        else o_ent = ent(XDPC_CLS_MCODE, 3'h0);
      end
      8'hdd: begin
        if (!reg_form && rf == 3'h0) o_ent = ent(XDPC_CLS_FAST, P_AMS);
        else if (!reg_form && (rf == 3'h2 || rf == 3'h3)) o_ent = ent(XDPC_CLS_FAST, P_AM);
        else if (!reg_form) o_ent = ent(XDPC_CLS_MCODE, 3'h0);
        else if (rf == 3'h4 || rf == 3'h5) o_ent = ent(XDPC_CLS_FAST, P_A);
        else o_ent = ent(XDPC_CLS_FAST, P_AM);
      end
      `XDPC_OP_ESC: begin
        if (i_op1 == `XDPC_OP_VSIMD || i_op1 == `XDPC_OP_PREF
            || i_op1 == `XDPC_OP_PREF_SSE)
          o_ent = ent(XDPC_CLS_FAST, P_AM);
        else if (i_op1 == 8'h7e || i_op1 == 8'h6e) o_ent = ent(XDPC_CLS_FAST, P_S);
        else if (i_op1 == 8'h77 || i_op1 == 8'ha2) o_ent = ent(XDPC_CLS_MCODE, 3'h0);
        else if (i_op1[7:4] == 4'hd || i_op1[7:4] == 4'he || i_op1[7:4] == 4'hf)
          o_ent = ent(XDPC_CLS_FAST, (i_op1[3:0] == 4'h5) ? P_M : P_AM);
        else o_ent = ent(XDPC_CLS_FAST, 3'h0);
      end
      default: o_ent = ent(i_has_modrm ? XDPC_CLS_FAST : XDPC_CLS_FAST, 3'h0);
    endcase
  end
endmodule : xdpc_lut
`default_nettype wire

// file: tb/xdpc_sched_model.sv
// downstream scheduler model raising stall as back-pressure
`timescale 1ns/1ps
`default_nettype none
module xdpc_sched_model (
  input  wire logic i_core_clk,
  input  wire logic i_arst_n,
  input  wire logic i_slow,
  output logic      o_stall
);
  // --------------------------------------------------------------
  // stall pattern: never when prompt, pseudo random when slow
  // --------------------------------------------------------------
  logic [7:0] lfsr_q;
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lfsr_q  <= 8'h5a;
      o_stall <= 1'b0;
    end else begin
      lfsr_q  <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      o_stall <= i_slow & (lfsr_q[1] | lfsr_q[6]);
    end
  end
endmodule : xdpc_sched_model
`default_nettype wire

// file: tb/xdpc_decode_tb_top.sv
// self-checking bench of the three-lane decode stage
`timescale 1ns/1ps
`default_nettype none
module xdpc_decode_tb_top;
  import xdpc_pkg::*;
  typedef struct packed {
    logic [7:0] op0; logic [7:0] op1; logic two; logic [2:0] regf; logic rform;
    logic [1:0] cls; logic [2:0] pipes; logic [1:0] kind; logic lp; logic stk; logic vs;
    logic pf;
  } xdpc_tb_ent_s;
  // --------------------------------------------------------------
  // clock, reset, stimulus signals
  // --------------------------------------------------------------
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        slow = 1'b0;
  wire  logic  stall;
  logic [2:0]  valid = 3'h0, two = 3'h0, hasm = 3'h0, rio = 3'h0;
  logic [23:0] op0 = 24'h0, op1 = 24'h0, modrm = 24'h0, trail = 24'h0;
  logic [8:0]  opcr = 9'h0;
  logic [5:0]  size = 6'h0;
  logic [95:0] addr = 96'h0;
  logic [2:0]  ix [3];
  logic [2:0]  o_valid, o_reg_form, o_prefetch;
  logic        o_ready;
  logic [5:0]  o_cls, o_size, o_kind;
  logic [8:0]  o_pipes, o_primary_reg, o_secondary_reg, o_stack_ofs;
  logic [23:0] o_vs_opcode;
  logic [95:0] o_line_addr;
  logic [2:0]  c_v, c_rio;  logic [23:0] c_m, c_t;  logic [8:0] c_or;
  logic [5:0]  c_s;  logic [95:0] c_a;  logic [2:0] c_ix [3];
  int failures = 0, cmp_count = 0, cyc = 0;
  logic [31:0] seed = 32'd91;
  always #12.5 clk = ~clk;
  xdpc_decode #(.LANES(3), .AW(32)) dut_u (.i_core_clk(clk), .i_arst_n(arst_n),
    .i_valid(valid), .o_ready(o_ready), .i_op0(op0), .i_op1(op1), .i_two_byte(two),
    .i_modrm(modrm), .i_has_modrm(hasm), .i_opc_reg(opcr), .i_reg_in_opc(rio),
    .i_size(size), .i_trail(trail), .i_addr(addr), .i_stall(stall), .o_valid(o_valid),
    .o_cls(o_cls), .o_pipes(o_pipes), .o_reg_form(o_reg_form),
    .o_primary_reg(o_primary_reg), .o_secondary_reg(o_secondary_reg), .o_size(o_size),
    .o_kind(o_kind), .o_stack_ofs(o_stack_ofs), .o_vs_opcode(o_vs_opcode),
    .o_prefetch(o_prefetch), .o_line_addr(o_line_addr));
  xdpc_sched_model part_u (.i_core_clk(clk), .i_arst_n(arst_n), .i_slow(slow),
    .o_stall(stall));
  // --------------------------------------------------------------
  // helpers: random source, encoding table, compare, verdict
  // --------------------------------------------------------------
  function automatic logic [31:0] nxt();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : nxt
  function automatic xdpc_tb_ent_s ent(input logic [2:0] i);
    case (i)
      3'h0: return {8'hd8, 8'h00, 1'b0, 3'h4, 1'b0, 2'h1, 3'h1, 2'h1, 4'h0};
      3'h1: return {8'hd8, 8'h00, 1'b0, 3'h4, 1'b1, 2'h1, 3'h1, 2'h1, 4'h4};
      3'h2: return {8'hda, 8'h00, 1'b0, 3'h0, 1'b0, 2'h3, 3'h0, 2'h1, 4'h0};
      3'h3: return {8'hdf, 8'h00, 1'b0, 3'h0, 1'b0, 2'h1, 3'h4, 2'h1, 4'h0};
      3'h4: return {8'hd9, 8'h00, 1'b0, 3'h0, 1'b1, 2'h1, 3'h3, 2'h1, 4'h4};
      3'h5: return {8'hd9, 8'h00, 1'b0, 3'h1, 1'b1, 2'h1, 3'h7, 2'h1, 4'h0};
      3'h6: return {8'h0f, 8'h0f, 1'b1, 3'h2, 1'b1, 2'h1, 3'h0, 2'h3, 4'ha};
      default: return {8'h0f, 8'h0d, 1'b1, 3'h0, 1'b0, 2'h1, 3'h0, 2'h3, 4'h9};
    endcase
  endfunction : ent
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    if (failures == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  // --------------------------------------------------------------
  // one cycle of random lanes, with a hand-made prefetch corner
  // --------------------------------------------------------------
  task automatic drive();
    xdpc_tb_ent_s e;
    logic [31:0]  r, ad;
    logic [2:0]   k;
    logic [1:0]   md;
    for (int l = 0; l < 3; l++) begin
      r = nxt();
      k = r[2:0];
      ad = nxt();
      if (l == 2 && cyc[5:0] == 6'h0) begin
        k = 3'h7;
        ad = 32'hffffffff;
      end
      e = ent(k);
      md = e.rform ? 2'h3 : 2'(r[9:8] % 3);
      ix[l] <= k;
      op0[l*8+:8] <= e.op0;
      op1[l*8+:8] <= e.op1;
      two[l] <= e.two;
      hasm[l] <= 1'b1;
      modrm[l*8+:8] <= {md, e.regf, r[12:10]};
      opcr[l*3+:3] <= r[15:13];
      rio[l] <= r[16];
      size[l*2+:2] <= 2'(r[19:17] % 3);
      trail[l*8+:8] <= r[27:20];
      addr[l*32+:32] <= ad;
      valid[l] <= r[28] | r[29];
    end
  endtask : drive
  // --------------------------------------------------------------
  // capture of each accepted group; held while stalled
  // --------------------------------------------------------------
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      c_v <= 3'h0;
    end else begin
      cyc <= cyc + 1;
      if (cyc > 4000) begin
        failures++;
        results();
      end else if (!stall) begin
        c_v <= valid;  c_m <= modrm;  c_t <= trail;  c_or <= opcr;
        c_rio <= rio;  c_s <= size;  c_a <= addr;  c_ix <= ix;
      end
    end
  end
  always @(negedge clk) begin
    xdpc_tb_ent_s e;
    logic [7:0]   m;
    if (!arst_n) begin
      chk(o_valid, 3'h0);
    end else begin
      chk(o_ready, !stall);
      for (int l = 0; l < 3; l++) begin
        chk(o_valid[l], c_v[l]);
        if (c_v[l]) begin
          e = ent(c_ix[l]);
          m = c_m[l*8+:8];
          chk(o_reg_form[l], m[7:6] == 2'h3);
          chk(o_primary_reg[l*3+:3], c_rio[l] ? c_or[l*3+:3] : m[5:3]);
          chk(o_secondary_reg[l*3+:3], m[2:0]);
          chk(o_size[l*2+:2], c_s[l*2+:2]);
          chk(o_cls[l*2+:2], e.cls);
          if (!e.lp) chk(o_pipes[l*3+:3], e.pipes);
          if (!e.pf) chk(o_kind[l*2+:2], e.kind);
          if (e.stk) chk(o_stack_ofs[l*3+:3], m[2:0]);
          if (e.vs) chk(o_vs_opcode[l*8+:8], c_t[l*8+:8]);
          chk(o_prefetch[l], e.pf);
          if (e.pf) chk(o_line_addr[l*32+:32], c_a[l*32+:32] & 32'hffffffc0);
        end
      end
    end
  end
  // --------------------------------------------------------------
  // main sequence: prompt, back-pressured, reset in mid-run
  // --------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (400) begin
      @(posedge clk);
      drive();
    end
    slow <= 1'b1;
    repeat (400) begin
      @(posedge clk);
      drive();
    end
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    arst_n <= 1'b1;
    slow <= 1'b0;
    repeat (200) begin
      @(posedge clk);
      drive();
    end
    @(posedge clk);
    results();
  end
endmodule : xdpc_decode_tb_top
`default_nettype wire
